/* File: core/pbcs_consts.svh */
`ifndef PBCS_CONSTS_SVH
`define PBCS_CONSTS_SVH
// Register indexes seen through the indirect access path
`define PBCS_IDX_CTRL 5'h00
`define PBCS_IDX_STAT 5'h01
`define PBCS_IDX_ID_HI 5'h02
`define PBCS_IDX_ID_LO 5'h03
`define PBCS_IDX_ADV 5'h04
// Basic control bit positions
`define PBCS_CTRL_SRST 15
`define PBCS_CTRL_LOOP 14
`define PBCS_CTRL_SPEED 13
`define PBCS_CTRL_AN_EN 12
`define PBCS_CTRL_PDOWN 11
`define PBCS_CTRL_AN_RESTART 9
`define PBCS_CTRL_DUPLEX 8
`define PBCS_CTRL_COL_TEST 7
`define PBCS_CTRL_WMASK 16'hfb80
`define PBCS_CTRL_RESET_VAL 16'h0000
// Basic status bit positions
`define PBCS_STAT_CAPS 16'h7800
`define PBCS_STAT_AN_DONE 5
`define PBCS_STAT_RFAULT 4
`define PBCS_STAT_AN_ABLE 3
`define PBCS_STAT_LINK 2
`define PBCS_STAT_JABBER 1
`define PBCS_STAT_EXT 0
// Advertisement bit positions
`define PBCS_ADV_RFAULT 13
`define PBCS_ADV_PAUSE_HI 11
`define PBCS_ADV_PAUSE_LO 10
`define PBCS_ADV_100FD 8
`define PBCS_ADV_100HD 7
`define PBCS_ADV_10FD 6
`define PBCS_ADV_10HD 5
`define PBCS_ADV_WMASK 16'h2dff
`define PBCS_ADV_RESET_VAL 16'h0081
// Pause field encodings
`define PBCS_PAUSE_NONE 2'h0
`define PBCS_PAUSE_SYM 2'h1
`define PBCS_PAUSE_ASYM 2'h2
`define PBCS_PAUSE_BOTH 2'h3
// Cycles the filtered strap must settle after reset release
`define PBCS_STRAP_SETTLE 2'h3
`endif

/* File: core/pbcs_pkg.sv */
package pbcs_pkg;
  // One register request from the MAC side
  typedef struct packed {
    logic write;
    logic [4:0] index;
    logic [15:0] wdata;
  } pbcs_req_t;
  // Conditions reported by the PHY core
  typedef struct packed {
    logic link_up;
    logic remote_fault;
    logic jabber;
    logic an_done;
    logic [1:0] lp_pause;
  } pbcs_line_t;
  // Operating mode driven to the PHY core
  typedef struct packed {
    logic loopback;
    logic an_enable;
    logic speed_100;
    logic full_duplex;
    logic power_down;
    logic col_test;
  } pbcs_mode_t;
  // Bank sequencing states
  typedef enum logic [1:0] {
    PBCS_ST_STRAP,
    PBCS_ST_RUN,
    PBCS_ST_SRST
  } pbcs_state_t;
endpackage : pbcs_pkg

/* File: core/pbcs_regs.sv */
`timescale 1ns/1ps
`include "pbcs_consts.svh"

// Function
// - Control bit 15 soft reset, self-clearing
// - Control bit 14 selects loopback
// - Bit 13 speed, ignored under autoneg
// - Bit 12 enables autoneg, overrides manual
// - Bit 11 general power down
// - Bit 9 restarts autoneg, self-clearing
// - Bit 8 duplex, ignored under autoneg
// - Bit 7 enables collision test
// - Strap sets speed, autoneg, advert defaults
// - Status 15..11 fixed capability flags
// - Status 5 shows autoneg complete
// - Status 4 remote fault latches high
// - Status 2 link latches low
// - Status 1 jabber latches high
// - Status 3 and 0 read one
// - Identifier high holds OUI middle bits
// - Identifier low holds OUI, model, revision
// - Advert bit 13 writable remote fault
// - Two-bit pause field, resets none
// - Both pause kinds resolve to one
// - Advert ability bits, 100 half resets one
// - Selector field writable, resets 00001
// - Registers reached by index, not memory
module pbcs_regs #(
  parameter logic [15:0] ID_OUI_MID = 16'h0a5c, // Arbitrary value
  parameter logic [5:0] ID_OUI_TOP = 6'h15, // Arbitrary value
  parameter logic [5:0] ID_MODEL = 6'h2a, // Arbitrary value
  parameter logic [3:0] ID_REV = 4'h3 // Arbitrary value
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic speed_sel_strap_in,
  input wire logic req_valid_in,
  input wire pbcs_pkg::pbcs_req_t req_in,
  output logic req_ready_out,
  output logic rd_valid_out,
  output logic [15:0] rd_data_out,
  input wire pbcs_pkg::pbcs_line_t line_in,
  input wire logic an_restart_taken_in,
  output pbcs_pkg::pbcs_mode_t mode_out,
  output logic [15:0] adv_word_out,
  output logic soft_reset_out,
  output logic an_restart_out,
  output logic [1:0] pause_mode_out
);

  // Index compare, shared by read and write decode
  function automatic logic idx_hit(
    input logic [4:0] idx,
    input logic [4:0] want
  );
    return idx == want;
  endfunction : idx_hit

  // Control defaults, speed and autoneg from strap
  function automatic logic [15:0] ctrl_dflt(
    input logic strap
  );
    logic [15:0] v;
    v = `PBCS_CTRL_RESET_VAL;
    v[`PBCS_CTRL_SPEED] = strap;
    v[`PBCS_CTRL_AN_EN] = strap;
    return v;
  endfunction : ctrl_dflt

  // Advertisement defaults, three abilities from strap
  function automatic logic [15:0] adv_dflt(
    input logic strap
  );
    logic [15:0] v;
    v = `PBCS_ADV_RESET_VAL;
    v[`PBCS_ADV_100FD] = strap;
    v[`PBCS_ADV_10FD] = strap;
    v[`PBCS_ADV_10HD] = strap;
    return v;
  endfunction : adv_dflt

  // Pause outcome, never both kinds at once
  function automatic logic [1:0] pause_resolve(
    input logic [1:0] local_adv,
    input logic [1:0] partner
  );
    logic [1:0] r;
    r = `PBCS_PAUSE_NONE;
    case (local_adv)
      `PBCS_PAUSE_BOTH: begin
        // Symmetric preferred, else asymmetric
        if (partner[0]) begin
          r = `PBCS_PAUSE_SYM;
        end else if (partner[1]) begin
          r = `PBCS_PAUSE_ASYM;
        end
      end
      `PBCS_PAUSE_SYM: begin
        // Needs partner symmetric support
        if (partner[0]) begin
          r = `PBCS_PAUSE_SYM;
        end
      end
      `PBCS_PAUSE_ASYM: begin
        // Needs partner asymmetric support
        if (partner[1]) begin
          r = `PBCS_PAUSE_ASYM;
        end
      end
      default: begin
        // No pause advertised
        r = `PBCS_PAUSE_NONE;
      end
    endcase
    return r;
  endfunction : pause_resolve

  // Strap synchroniser stages; first read only by second
  logic strap_s1_reg;
  logic strap_s2_reg;
  logic strap_s3_reg;
  logic strap_lvl_reg; // Filtered strap level
  logic strap_lvl_next;

  // Sequencing state and settle count
  pbcs_pkg::pbcs_state_t state_reg;
  pbcs_pkg::pbcs_state_t state_next;
  logic [1:0] settle_reg;
  logic [1:0] settle_next;

  // Stored register contents
  logic [15:0] ctrl_reg; // Writable control bits
  logic [15:0] ctrl_next;
  logic [15:0] adv_reg; // Writable advert bits
  logic [15:0] adv_next;

  // Latched status conditions
  logic rfault_reg;
  logic rfault_next;
  logic jabber_reg;
  logic jabber_next;
  logic link_reg;
  logic link_next;

  // Answer and event outputs
  logic [15:0] rd_data_reg;
  logic [15:0] rd_data_next;
  logic rd_valid_reg;
  logic rd_valid_next;
  logic srst_pulse_reg;
  logic srst_pulse_next;
  logic [1:0] pause_reg;
  logic [1:0] pause_next;

  // Decoded request and assembled words
  logic taken; // Request accepted this cycle
  logic wr_ctrl;
  logic wr_adv;
  logic rd_stat; // Status read, clears latches
  logic [15:0] stat_word;
  logic [15:0] rd_word;

  // Ready falls with the enable, so a frozen bank never takes a request
  // and the MAC side simply holds its request until the bank runs again
  // Requests accepted only while running
  assign req_ready_out = ce_in && (state_reg == pbcs_pkg::PBCS_ST_RUN);
  assign taken = req_valid_in && req_ready_out;

  // Write and read strobes by index
  assign wr_ctrl = taken && req_in.write && idx_hit(req_in.index, `PBCS_IDX_CTRL);
  assign wr_adv = taken && req_in.write && idx_hit(req_in.index, `PBCS_IDX_ADV);
  assign rd_stat = taken && !req_in.write && idx_hit(req_in.index, `PBCS_IDX_STAT);

  // Status word from capabilities and latches
  // Fault and jabber latch bits OR the live condition, so a fault in the read cycle shows; link shows the latch alone
  always_comb begin
    stat_word = `PBCS_STAT_CAPS;
    stat_word[`PBCS_STAT_AN_DONE] = line_in.an_done;
    stat_word[`PBCS_STAT_RFAULT] = rfault_reg || line_in.remote_fault;
    stat_word[`PBCS_STAT_AN_ABLE] = 1'b1;
    stat_word[`PBCS_STAT_LINK] = link_reg;
    stat_word[`PBCS_STAT_JABBER] = jabber_reg || line_in.jabber;
    stat_word[`PBCS_STAT_EXT] = 1'b1;
  end

  // Read multiplexer; unknown index reads zero
  // Indexes above four belong to registers outside this bank
  always_comb begin
    rd_word = 16'h0000;
    if (idx_hit(req_in.index, `PBCS_IDX_CTRL)) begin
      rd_word = ctrl_reg & `PBCS_CTRL_WMASK;
    end else if (idx_hit(req_in.index, `PBCS_IDX_STAT)) begin
      rd_word = stat_word;
    end else if (idx_hit(req_in.index, `PBCS_IDX_ID_HI)) begin
      rd_word = ID_OUI_MID;
    end else if (idx_hit(req_in.index, `PBCS_IDX_ID_LO)) begin
      rd_word = {ID_OUI_TOP, ID_MODEL, ID_REV};
    end else if (idx_hit(req_in.index, `PBCS_IDX_ADV)) begin
      rd_word = adv_reg & `PBCS_ADV_WMASK;
    end
  end

  // Strap filter: accept level once stages two and three agree
  // One disagreeing sample keeps the last accepted level
  always_comb begin
    strap_lvl_next = strap_lvl_reg;
    if (strap_s2_reg == strap_s3_reg) begin
      strap_lvl_next = strap_s3_reg;
    end
  end

  // Strap synchroniser registers; they keep sampling through reset, so the
  // filtered level is already settled when the defaults load after release
  always_ff @(posedge sys_clk_in) begin
    if (reset_in || ce_in) begin
      strap_s1_reg <= speed_sel_strap_in;
      strap_s2_reg <= strap_s1_reg;
      strap_s3_reg <= strap_s2_reg;
      strap_lvl_reg <= strap_lvl_next;
    end
  end

  // Next values for the bank
  // Every next value but rd_valid_next and srst_pulse_next, which default low, holds unless a branch below moves it
  always_comb begin
    state_next = state_reg;
    settle_next = settle_reg;
    ctrl_next = ctrl_reg;
    adv_next = adv_reg;
    rfault_next = rfault_reg;
    jabber_next = jabber_reg;
    link_next = link_reg;
    rd_data_next = rd_data_reg;
    rd_valid_next = 1'b0;
    srst_pulse_next = 1'b0;
    pause_next = pause_reg;

    // Latch-high faults; an event beats the read clear
    if (line_in.remote_fault) begin
      rfault_next = 1'b1;
    end else if (rd_stat) begin
      rfault_next = 1'b0;
    end
    if (line_in.jabber) begin
      jabber_next = 1'b1;
    end else if (rd_stat) begin
      jabber_next = 1'b0;
    end

    // Latch-low link; a loss beats the read refresh
    // After reset the link reads down through the first status read, since that read sets the latch
    if (!line_in.link_up) begin
      link_next = 1'b0;
    end else if (rd_stat) begin
      link_next = 1'b1;
    end

    // Pause outcome held only while autoneg is complete
    if (line_in.an_done) begin
      pause_next = pause_resolve(adv_reg[`PBCS_ADV_PAUSE_HI:`PBCS_ADV_PAUSE_LO], line_in.lp_pause);
    end else begin
      pause_next = `PBCS_PAUSE_NONE;
    end

    // Restart bit clears once the engine takes it
    if (an_restart_taken_in) begin
      ctrl_next[`PBCS_CTRL_AN_RESTART] = 1'b0;
    end

    // Read answer one cycle after the taken edge
    if (taken && !req_in.write) begin
      rd_data_next = rd_word;
      rd_valid_next = 1'b1;
    end

    case (state_reg)
      pbcs_pkg::PBCS_ST_STRAP: begin
        // Wait for the filtered strap, then load defaults
        // The filter runs through reset, so its level is settled here
        if (settle_reg == `PBCS_STRAP_SETTLE) begin
          ctrl_next = ctrl_dflt(strap_lvl_reg);
          adv_next = adv_dflt(strap_lvl_reg);
          state_next = pbcs_pkg::PBCS_ST_RUN;
        end else begin
          settle_next = settle_reg + 2'h1;
        end
      end
      pbcs_pkg::PBCS_ST_RUN: begin
        // Control write, writable bits only
        // A restart written in the cycle the core takes the old one wins
        if (wr_ctrl) begin
          ctrl_next = req_in.wdata & `PBCS_CTRL_WMASK;
          if (!req_in.wdata[`PBCS_CTRL_AN_RESTART] && an_restart_taken_in) begin
            ctrl_next[`PBCS_CTRL_AN_RESTART] = 1'b0;
          end
          if (req_in.wdata[`PBCS_CTRL_SRST]) begin
            state_next = pbcs_pkg::PBCS_ST_SRST;
          end
        end
        // Advertisement write, writable bits only
        if (wr_adv) begin
          adv_next = req_in.wdata & `PBCS_ADV_WMASK;
        end
      end
      pbcs_pkg::PBCS_ST_SRST: begin
        // Soft reset reloads defaults and clears bit 15
        ctrl_next = ctrl_dflt(strap_lvl_reg);
        adv_next = adv_dflt(strap_lvl_reg);
        // Status latches restart from their idle values
        rfault_next = 1'b0;
        jabber_next = 1'b0;
        link_next = 1'b0;
        srst_pulse_next = 1'b1;
        state_next = pbcs_pkg::PBCS_ST_RUN;
      end
      default: begin
        // Recover to the strap load
        state_next = pbcs_pkg::PBCS_ST_STRAP;
        settle_next = 2'h0;
      end
    endcase
  end

  // Bank registers
  // Reset acts whatever the enable; a low enable holds every flop
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      state_reg <= pbcs_pkg::PBCS_ST_STRAP;
      settle_reg <= 2'h0;
      ctrl_reg <= `PBCS_CTRL_RESET_VAL;
      adv_reg <= `PBCS_ADV_RESET_VAL;
      rfault_reg <= 1'b0;
      jabber_reg <= 1'b0;
      link_reg <= 1'b0;
      rd_data_reg <= 16'h0000;
      rd_valid_reg <= 1'b0;
      srst_pulse_reg <= 1'b0;
      pause_reg <= `PBCS_PAUSE_NONE;
    end else if (ce_in) begin
      state_reg <= state_next;
      settle_reg <= settle_next;
      ctrl_reg <= ctrl_next;
      adv_reg <= adv_next;
      rfault_reg <= rfault_next;
      jabber_reg <= jabber_next;
      link_reg <= link_next;
      rd_data_reg <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
      srst_pulse_reg <= srst_pulse_next;
      pause_reg <= pause_next;
    end
  end

  // Mode to the PHY core; manual speed and duplex only without autoneg
  // The core sees the forced values, the register reads back as written
  assign mode_out.loopback = ctrl_reg[`PBCS_CTRL_LOOP];
  assign mode_out.an_enable = ctrl_reg[`PBCS_CTRL_AN_EN];
  assign mode_out.speed_100 = ctrl_reg[`PBCS_CTRL_SPEED] && !ctrl_reg[`PBCS_CTRL_AN_EN];
  assign mode_out.full_duplex = ctrl_reg[`PBCS_CTRL_DUPLEX] && !ctrl_reg[`PBCS_CTRL_AN_EN];
  assign mode_out.power_down = ctrl_reg[`PBCS_CTRL_PDOWN];
  assign mode_out.col_test = ctrl_reg[`PBCS_CTRL_COL_TEST];

  // Remaining outputs straight from flops
  // Soft reset is a one-cycle pulse; the restart level waits for the core
  assign adv_word_out = adv_reg & `PBCS_ADV_WMASK;
  assign an_restart_out = ctrl_reg[`PBCS_CTRL_AN_RESTART];
  assign soft_reset_out = srst_pulse_reg;
  assign pause_mode_out = pause_reg;
  assign rd_valid_out = rd_valid_reg;
  assign rd_data_out = rd_data_reg;

endmodule : pbcs_regs

/* File: sim/pbcs_regs_checker.sv */
`timescale 1ns/1ps
// Watches the register bank ports for timing and status relations
module pbcs_regs_checker (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic speed_sel_strap_in,
  input wire logic req_valid_in,
  input wire pbcs_pkg::pbcs_req_t req_in,
  input wire logic req_ready_out,
  input wire logic rd_valid_out,
  input wire logic [15:0] rd_data_out,
  input wire pbcs_pkg::pbcs_line_t line_in,
  input wire logic an_restart_taken_in,
  input wire pbcs_pkg::pbcs_mode_t mode_out,
  input wire logic [15:0] adv_word_out,
  input wire logic soft_reset_out,
  input wire logic an_restart_out,
  input wire logic [1:0] pause_mode_out
);
  // Single clock domain
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  // Read taken at this edge
  sequence rd_s;
    req_valid_in && req_ready_out && !req_in.write;
  endsequence
  // Status read taken at this edge
  sequence stat_rd_s;
    rd_s ##0 req_in.index == 5'h01;
  endsequence
  // Control write taken at this edge
  sequence ctrl_wr_s;
    req_valid_in && req_ready_out && req_in.write && req_in.index == 5'h00;
  endsequence
  rd_answer_a: assert property (rd_s |=> rd_valid_out)
    else $error("read answer missing");
  ready_settle_a: assert property ($fell(reset_in) |-> !req_ready_out [*4] ##1 req_ready_out)
    else $error("ready timing after reset wrong");
  soft_reset_a: assert property (ctrl_wr_s ##0 req_in.wdata[15] |=> !req_ready_out ##1 (soft_reset_out && req_ready_out))
    else $error("soft reset sequence wrong");
  restart_set_a: assert property (ctrl_wr_s ##0 (req_in.wdata[9] && !req_in.wdata[15]) |=> an_restart_out)
    else $error("restart not raised");
  restart_clear_a: assert property (an_restart_out && an_restart_taken_in && !req_valid_in |=> !an_restart_out)
    else $error("restart not cleared");
  manual_mask_a: assert property (mode_out.an_enable |-> !mode_out.speed_100 && !mode_out.full_duplex)
    else $error("manual mode leaks under autoneg");
  pause_gate_a: assert property (!line_in.an_done |=> pause_mode_out == 2'h0)
    else $error("pause resolved without autoneg");
  pause_single_a: assert property (pause_mode_out != 2'h3)
    else $error("pause resolved to both");
  status_fixed_a: assert property (stat_rd_s |=> rd_data_out[15:6] == 10'h1e0 && rd_data_out[3] && rd_data_out[0])
    else $error("fixed status bits wrong");
  link_low_a: assert property (!line_in.link_up ##1 stat_rd_s |=> !rd_data_out[2])
    else $error("link loss not latched");
  fault_high_a: assert property (line_in.remote_fault ##1 stat_rd_s |=> rd_data_out[4])
    else $error("remote fault not latched");
  jabber_high_a: assert property (line_in.jabber ##1 stat_rd_s |=> rd_data_out[1])
    else $error("jabber not latched");
  adv_reserved_a: assert property (adv_word_out[15:14] == 2'h0 && !adv_word_out[12] && !adv_word_out[9])
    else $error("reserved advert bits set");
endmodule : pbcs_regs_checker

/* File: sim/pbcs_core_model.sv */
`timescale 1ns/1ps
// PHY core stand-in: accepts autoneg restarts after a set delay
module pbcs_core_model (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic an_restart_in,
  input wire logic [3:0] delay_in,
  output logic taken_out
);
  logic [3:0] wait_reg; // Cycles waited on the pending restart
  // Count while a restart is pending, then pulse acceptance once
  always_ff @(posedge sys_clk_in) begin
    if (reset_in || !an_restart_in || taken_out) begin
      wait_reg <= 4'h0;
      taken_out <= 1'b0;
    end else if (wait_reg >= delay_in) begin
      taken_out <= 1'b1;
    end else begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule : pbcs_core_model

/* File: sim/pbcs_regs_tb_top.sv */
`timescale 1ns/1ps
// Self-checking bench for the PHY register bank
module pbcs_regs_tb_top;
  logic sys_clk_in = 1'b0; // 40 MHz clock
  logic reset_in = 1'b1; // Synchronous reset
  logic ce_in = 1'b1; // Enable, on except in the enable test
  logic speed_sel_strap_in = 1'b1; // Strap level
  logic req_valid_in = 1'b0;
  pbcs_pkg::pbcs_req_t req_in = '0;
  pbcs_pkg::pbcs_line_t line_in = '0;
  pbcs_pkg::pbcs_mode_t mode_out;
  logic req_ready_out, rd_valid_out, soft_reset_out, an_restart_out, an_restart_taken_in;
  logic [15:0] rd_data_out, adv_word_out;
  logic [15:0] rd, ctrl, adv; // Last read and shadow registers
  logic [1:0] pause_mode_out;
  logic [3:0] dly = 4'h0; // Core restart acceptance delay
  int n_errors = 0;
  int check_count = 0;
  always #12.5 sys_clk_in = ~sys_clk_in;
  pbcs_regs pbcs_regs_inst (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .speed_sel_strap_in(speed_sel_strap_in),
    .req_valid_in(req_valid_in),
    .req_in(req_in),
    .req_ready_out(req_ready_out),
    .rd_valid_out(rd_valid_out),
    .rd_data_out(rd_data_out),
    .line_in(line_in),
    .an_restart_taken_in(an_restart_taken_in),
    .mode_out(mode_out),
    .adv_word_out(adv_word_out),
    .soft_reset_out(soft_reset_out),
    .an_restart_out(an_restart_out),
    .pause_mode_out(pause_mode_out)
  );
  pbcs_core_model pbcs_core_model_inst (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .an_restart_in(an_restart_out), .delay_in(dly), .taken_out(an_restart_taken_in));
  // Compare and count
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // One register access, held until taken
  task automatic acc(input logic wr, input logic [4:0] idx, input logic [15:0] d);
    int n;
    @(negedge sys_clk_in);
    req_valid_in = 1'b1;
    req_in = '{wr, idx, d};
    n = 0;
    while (req_ready_out !== 1'b1 && n < 20) begin
      @(negedge sys_clk_in);
      n++;
    end
    if (n >= 20) chk("ready", {15'h0, req_ready_out}, 16'h0001);
    @(negedge sys_clk_in);
    req_valid_in = 1'b0;
    rd = rd_data_out;
    if (!wr) chk("rd_valid", {15'h0, rd_valid_out}, 16'h0001);
  endtask : acc
  // Expected read value, quiet line assumed for status
  function automatic logic [15:0] exp_reg(input logic [4:0] idx);
    case (idx)
      5'h00: return ctrl;
      5'h01: return 16'h7809;
      5'h02: return 16'h0a5c;
      5'h03: return {6'h15, 6'h2a, 4'h3};
      5'h04: return adv;
      default: return 16'h0000;
    endcase
  endfunction : exp_reg
  // Expected mode word from the shadow control
  function automatic logic [15:0] exp_mode();
    return {10'h0, ctrl[14], ctrl[12], ctrl[13] & ~ctrl[12], ctrl[8] & ~ctrl[12], ctrl[11], ctrl[7]};
  endfunction : exp_mode
  // Expected pause resolution
  function automatic logic [1:0] exp_pause(input logic [1:0] l, input logic [1:0] p);
    if (l == 2'h3) return p[0] ? 2'h1 : (p[1] ? 2'h2 : 2'h0);
    if (l == 2'h1) return p[0] ? 2'h1 : 2'h0;
    if (l == 2'h2) return p[1] ? 2'h2 : 2'h0;
    return 2'h0;
  endfunction : exp_pause
  // Reset with a given strap, shadows take the strap defaults
  task automatic do_reset(input logic s);
    speed_sel_strap_in = s;
    reset_in = 1'b1;
    repeat (8) @(negedge sys_clk_in);
    reset_in = 1'b0;
    ctrl = s ? 16'h3000 : 16'h0000;
    adv = s ? 16'h01e1 : 16'h0081;
  endtask : do_reset
  // Read indexes 0 to 5 and the mode outputs
  task automatic check_all();
    for (int i = 0; i < 6; i++) begin
      acc(1'b0, i[4:0], 16'h0000);
      chk("reg", rd, exp_reg(i[4:0]));
    end
    chk("mode", {10'h0, mode_out}, exp_mode());
    chk("adv_word", adv_word_out, adv);
  endtask : check_all
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  // Watchdog sized well beyond the thousand or so cycles needed
  initial begin
    #500000;
    n_errors++;
    finish_test();
  end
  initial begin
    logic [15:0] d;
    logic [4:0] ix;
    int n;
    void'($urandom(40));
    // Defaults for both strap levels, then after soft reset
    for (int s = 0; s < 2; s++) begin
      do_reset(s == 0);
      check_all();
      acc(1'b1, 5'h00, 16'h7980);
      acc(1'b1, 5'h04, 16'hffff);
      acc(1'b1, 5'h00, 16'h8000);
      check_all();
      $display("defaults test done");
    end
    // Random writes with corners, read back the written index
    for (int i = 0; i < 200; i++) begin
      ix = 5'($urandom_range(5, 0));
      d = (i % 8 == 0) ? 16'h7dff : ((i % 8 == 1) ? 16'h0000 : 16'($urandom) & 16'h7dff);
      acc(1'b1, ix, d);
      if (ix == 5'h00) ctrl = d & 16'h7980;
      if (ix == 5'h04) adv = d & 16'h2dff;
      acc(1'b0, ix, 16'h0000);
      chk("readback", rd, exp_reg(ix));
      chk("mode", {10'h0, mode_out}, exp_mode());
    end
    $display("random access test done");
    // Latched status bits
    line_in = '{1'b1, 1'b0, 1'b0, 1'b0, 2'h0};
    for (int k = 0; k < 3; k++) acc(1'b0, 5'h01, 16'h0000);
    chk("link up", rd, 16'h780d);
    line_in = '{1'b0, 1'b1, 1'b1, 1'b0, 2'h0};
    acc(1'b0, 5'h01, 16'h0000);
    chk("status latched", rd, 16'h781b);
    line_in = '{1'b1, 1'b0, 1'b0, 1'b0, 2'h0};
    for (int k = 0; k < 3; k++) acc(1'b0, 5'h01, 16'h0000);
    chk("status cleared", rd, 16'h780d);
    $display("status latch test done");
    // Every local and partner pause code
    for (int l = 0; l < 4; l++) begin
      for (int p = 0; p < 4; p++) begin
        acc(1'b1, 5'h04, {4'h0, l[1:0], 10'h1e1});
        line_in = '{1'b1, 1'b0, 1'b0, 1'b1, p[1:0]};
        repeat (2) @(negedge sys_clk_in);
        chk("pause", {14'h0, pause_mode_out}, {14'h0, exp_pause(l[1:0], p[1:0])});
      end
    end
    acc(1'b0, 5'h01, 16'h0000);
    chk("an done", rd, 16'h782d);
    $display("pause test done");
    // Autoneg restart, core prompt and slow
    for (int k = 0; k < 4; k++) begin
      dly = 4'(k * 3);
      acc(1'b1, 5'h00, ctrl | 16'h0200);
      chk("restart set", {15'h0, an_restart_out}, 16'h0001);
      n = 0;
      while (an_restart_out !== 1'b0 && n < 40) begin
        @(negedge sys_clk_in);
        n++;
      end
      chk("restart cleared", {15'h0, an_restart_out}, 16'h0000);
    end
    $display("restart test done");
    // Enable low freezes the bank and drops ready
    ce_in = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    chk("frozen ready", {15'h0, req_ready_out}, 16'h0000);
    chk("frozen pause", {14'h0, pause_mode_out}, {14'h0, exp_pause(2'h3, 2'h3)});
    ce_in = 1'b1;
    acc(1'b0, 5'h04, 16'h0000);
    chk("adv after freeze", rd, {4'h0, 2'h3, 10'h1e1});
    $display("enable test done");
    finish_test();
  end
endmodule : pbcs_regs_tb_top
bind pbcs_regs pbcs_regs_checker pbcs_regs_checker_inst (
  .sys_clk_in(sys_clk_in),
  .reset_in(reset_in),
  .ce_in(ce_in),
  .speed_sel_strap_in(speed_sel_strap_in),
  .req_valid_in(req_valid_in),
  .req_in(req_in),
  .req_ready_out(req_ready_out),
  .rd_valid_out(rd_valid_out),
  .rd_data_out(rd_data_out),
  .line_in(line_in),
  .an_restart_taken_in(an_restart_taken_in),
  .mode_out(mode_out),
  .adv_word_out(adv_word_out),
  .soft_reset_out(soft_reset_out),
  .an_restart_out(an_restart_out),
  .pause_mode_out(pause_mode_out)
);
